// ### verilog/obs_pkg.sv
// Constants and types for the current observation register bank.
// Assumes a byte-wide register window reached through a 32-bit Avalon-MM slave.
package obs_pkg;

   // ---------------------------------------------------------------
   // Register indices (the bus address carries these values directly)
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_ALPHA_TEST = 16'h40e6;
   localparam logic [15:0] IDX_BETA_TEST = 16'h40e8;
   localparam logic [15:0] IDX_D_NOW = 16'h40ea;
   localparam logic [15:0] IDX_D_PREV = 16'h40ec;
   localparam logic [15:0] IDX_ANGLE_STEP = 16'h40ee;
   localparam logic [15:0] IDX_Q_NOW = 16'h40f0;
   localparam logic [15:0] IDX_Q_PREV = 16'h40f2;
   localparam logic [15:0] IDX_CURRENT_A = 16'h40f4;
   localparam logic [15:0] IDX_CURRENT_B = 16'h40f6;
   localparam logic [15:0] IDX_CURRENT_C = 16'h40f8;
   localparam logic [15:0] IDX_LAST = 16'h40f9;

   // ---------------------------------------------------------------
   // Word numbers inside the window
   // ---------------------------------------------------------------
   localparam logic [3:0] WORD_ALPHA_TEST = 4'h0;
   localparam logic [3:0] WORD_BETA_TEST = 4'h1;
   localparam logic [3:0] WORD_D_NOW = 4'h2;
   localparam logic [3:0] WORD_D_PREV = 4'h3;
   localparam logic [3:0] WORD_ANGLE_STEP = 4'h4;
   localparam logic [3:0] WORD_Q_NOW = 4'h5;
   localparam logic [3:0] WORD_Q_PREV = 4'h6;
   localparam logic [3:0] WORD_CURRENT_A = 4'h7;
   localparam logic [3:0] WORD_CURRENT_B = 4'h8;
   localparam logic [3:0] WORD_CURRENT_C = 4'h9;

   // ---------------------------------------------------------------
   // Reset values and bus answers
   // ---------------------------------------------------------------
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] READ_RESET = 32'h0000_0000;
   localparam logic [23:0] READ_PAD = 24'h00_0000;
   localparam logic WAIT_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_e;

endpackage : obs_pkg

// ### verilog/word_capture.sv
// Holding register that takes a new word on a load strobe.
// Assumes load and din come from logic on the same clock.
`timescale 1ns/10ps
module word_capture #(
   parameter int WIDTH = 16
) (
   input logic clk,
   input logic arst_n,
   input logic load,
   input logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
   } capture_s;

   capture_s cur;
   capture_s next;

   always_comb begin
      next = cur;
      if (load) begin
         next.value = din;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= next;
      end
   end

   assign q = cur.value;

endmodule : word_capture

// ### verilog/window_decode.sv
// Decodes a register index into word number and byte half.
// Assumes the window is a run of 16-bit words, high byte at the even index.
`timescale 1ns/10ps
module window_decode #(
   parameter logic [15:0] FIRST = 16'h0000,
   parameter logic [15:0] LAST = 16'h0001
) (
   input logic [15:0] index,
   output logic hit,
   output logic [3:0] word_sel,
   output logic low_byte
);

   logic [15:0] offset;

   always_comb begin
      offset = index - FIRST;
      if (index < FIRST) begin
         hit = 1'b0;
         word_sel = 4'h0;
         low_byte = 1'b0;
      end else if (index > LAST) begin
         hit = 1'b0;
         word_sel = 4'h0;
         low_byte = 1'b0;
      end else begin
         hit = 1'b1;
         word_sel = offset[4:1];
         low_byte = offset[0];
      end
   end

endmodule : window_decode

// ### verilog/observation_bank.sv
// Observation register bank of the motor-control engine.
// Assumes engine strobes and values come from logic on clk; software uses Avalon-MM.
//
// Summary of operation
// - The d-axis current from the coordinate transformation reads back as a signed 16-bit word.
// - A separate read-only word holds the d-axis current of the previous carrier wave.
// - The q-axis current from the coordinate transformation reads back as a signed 16-bit word.
// - A separate read-only word holds the q-axis current of the previous carrier wave.
// - The angle step per carrier wave is a signed word that software writes and reads.
// - Five injection test words read back and ignore every software write.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module observation_bank (
   input logic clk,
   input logic arst_n,
   input logic [15:0] address,
   input logic read,
   input logic write,
   input logic [31:0] writedata,
   input logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   input logic transform_valid,
   input logic [15:0] d_axis_current_in,
   input logic [15:0] q_axis_current_in,
   input logic carrier_tick,
   input logic injection_valid,
   input logic [15:0] injection_alpha_in,
   input logic [15:0] injection_beta_in,
   input logic [15:0] injection_current_a_in,
   input logic [15:0] injection_current_b_in,
   input logic [15:0] injection_current_c_in,
   output logic [15:0] carrier_angle_step
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      obs_pkg::bus_state_e bus;
      logic waitrequest;
      logic [31:0] readdata;
      logic [1:0] response;
      logic [15:0] angle;
      logic [7:0] angle_stage;
      logic stage_valid;
      logic [7:0] low_shadow;
      logic [3:0] shadow_word;
      logic shadow_valid;
   } bank_s;

   bank_s cur;
   bank_s next;

   logic hit;
   logic [3:0] word_sel;
   logic low_byte;
   logic [15:0] selected_word;
   logic [7:0] read_byte;
   logic write_ok;

   logic [15:0] d_axis_current_now;
   logic [15:0] d_axis_current_prev;
   logic [15:0] q_axis_current_now;
   logic [15:0] q_axis_current_prev;
   logic [15:0] injection_alpha_test;
   logic [15:0] injection_beta_test;
   logic [15:0] injection_current_test_a;
   logic [15:0] injection_current_test_b;
   logic [15:0] injection_current_test_c;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   window_decode #(
      .FIRST(obs_pkg::IDX_ALPHA_TEST),
      .LAST(obs_pkg::IDX_LAST)
   ) u_decode (
      .index(address),
      .hit(hit),
      .word_sel(word_sel),
      .low_byte(low_byte)
   );

   // ---------------------------------------------------------------
   // Transformation results and carrier-wave history
   // ---------------------------------------------------------------
   word_capture #(
      .WIDTH(16)
   ) u_d_now (
      .clk(clk),
      .arst_n(arst_n),
      .load(transform_valid),
      .din(d_axis_current_in),
      .q(d_axis_current_now)
   );

   word_capture #(
      .WIDTH(16)
   ) u_d_prev (
      .clk(clk),
      .arst_n(arst_n),
      .load(carrier_tick),
      .din(d_axis_current_now),
      .q(d_axis_current_prev)
   );

   word_capture #(
      .WIDTH(16)
   ) u_q_now (
      .clk(clk),
      .arst_n(arst_n),
      .load(transform_valid),
      .din(q_axis_current_in),
      .q(q_axis_current_now)
   );

   word_capture #(
      .WIDTH(16)
   ) u_q_prev (
      .clk(clk),
      .arst_n(arst_n),
      .load(carrier_tick),
      .din(q_axis_current_now),
      .q(q_axis_current_prev)
   );

   // ---------------------------------------------------------------
   // Injection test values
   // ---------------------------------------------------------------
   word_capture #(
      .WIDTH(16)
   ) u_alpha (
      .clk(clk),
      .arst_n(arst_n),
      .load(injection_valid),
      .din(injection_alpha_in),
      .q(injection_alpha_test)
   );

   word_capture #(
      .WIDTH(16)
   ) u_beta (
      .clk(clk),
      .arst_n(arst_n),
      .load(injection_valid),
      .din(injection_beta_in),
      .q(injection_beta_test)
   );

   word_capture #(
      .WIDTH(16)
   ) u_current_a (
      .clk(clk),
      .arst_n(arst_n),
      .load(injection_valid),
      .din(injection_current_a_in),
      .q(injection_current_test_a)
   );

   word_capture #(
      .WIDTH(16)
   ) u_current_b (
      .clk(clk),
      .arst_n(arst_n),
      .load(injection_valid),
      .din(injection_current_b_in),
      .q(injection_current_test_b)
   );

   word_capture #(
      .WIDTH(16)
   ) u_current_c (
      .clk(clk),
      .arst_n(arst_n),
      .load(injection_valid),
      .din(injection_current_c_in),
      .q(injection_current_test_c)
   );

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb begin
      case (word_sel)
         obs_pkg::WORD_ALPHA_TEST: begin
            selected_word = injection_alpha_test;
         end
         obs_pkg::WORD_BETA_TEST: begin
            selected_word = injection_beta_test;
         end
         obs_pkg::WORD_D_NOW: begin
            selected_word = d_axis_current_now;
         end
         obs_pkg::WORD_D_PREV: begin
            selected_word = d_axis_current_prev;
         end
         obs_pkg::WORD_ANGLE_STEP: begin
            selected_word = cur.angle;
         end
         obs_pkg::WORD_Q_NOW: begin
            selected_word = q_axis_current_now;
         end
         obs_pkg::WORD_Q_PREV: begin
            selected_word = q_axis_current_prev;
         end
         obs_pkg::WORD_CURRENT_A: begin
            selected_word = injection_current_test_a;
         end
         obs_pkg::WORD_CURRENT_B: begin
            selected_word = injection_current_test_b;
         end
         obs_pkg::WORD_CURRENT_C: begin
            selected_word = injection_current_test_c;
         end
         default: begin
            selected_word = obs_pkg::WORD_RESET;
         end
      endcase
   end

   // Low byte comes from the snapshot taken by the high-byte read of the same word, else from the live word
   always_comb begin
      if (!low_byte) begin
         read_byte = selected_word[15:8];
      end else if (cur.shadow_valid && (cur.shadow_word == word_sel)) begin
         read_byte = cur.low_shadow;
      end else begin
         read_byte = selected_word[7:0];
      end
   end

   // Only the angle step accepts writes; test words ignore them
   assign write_ok = hit && byteenable[0] && (word_sel == obs_pkg::WORD_ANGLE_STEP);

   // ---------------------------------------------------------------
   // Bus answer and register updates
   // ---------------------------------------------------------------
   always_comb begin
      next = cur;
      case (cur.bus)
         obs_pkg::BUS_IDLE: begin
            if (read || write) begin
               next.bus = obs_pkg::BUS_ANSWER;
               next.waitrequest = 1'b0;
               if (hit) begin
                  next.response = obs_pkg::RESP_OKAY;
               end else begin
                  next.response = obs_pkg::RESP_SLVERR;
               end
               if (read && hit) begin
                  next.readdata = {obs_pkg::READ_PAD, read_byte};
               end else begin
                  next.readdata = obs_pkg::READ_RESET;
               end
            end
         end
         obs_pkg::BUS_ANSWER: begin
            next.bus = obs_pkg::BUS_IDLE;
            next.waitrequest = obs_pkg::WAIT_RESET;
            if (read && hit && !low_byte) begin
               next.low_shadow = selected_word[7:0];
               next.shadow_word = word_sel;
               next.shadow_valid = 1'b1;
            end else if (read && hit && (cur.shadow_word == word_sel)) begin
               next.shadow_valid = 1'b0;
            end
            if (write && write_ok && !low_byte) begin
               next.angle_stage = writedata[7:0];
               next.stage_valid = 1'b1;
            end else if (write && write_ok) begin
               if (cur.stage_valid) begin
                  next.angle = {cur.angle_stage, writedata[7:0]};
               end else begin
                  next.angle = {cur.angle[15:8], writedata[7:0]};
               end
               next.stage_valid = 1'b0;
            end
         end
         default: begin
            next.bus = obs_pkg::BUS_IDLE;
            next.waitrequest = obs_pkg::WAIT_RESET;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur.bus <= obs_pkg::BUS_IDLE;
         cur.waitrequest <= obs_pkg::WAIT_RESET;
         cur.readdata <= obs_pkg::READ_RESET;
         cur.response <= obs_pkg::RESP_OKAY;
         cur.angle <= obs_pkg::WORD_RESET;
         cur.angle_stage <= obs_pkg::BYTE_RESET;
         cur.stage_valid <= 1'b0;
         cur.low_shadow <= obs_pkg::BYTE_RESET;
         cur.shadow_word <= obs_pkg::WORD_ALPHA_TEST;
         cur.shadow_valid <= 1'b0;
      end else begin
         cur <= next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign readdata = cur.readdata;
   assign waitrequest = cur.waitrequest;
   assign response = cur.response;
   assign carrier_angle_step = cur.angle;

endmodule : observation_bank

// ### testbench/observation_bank_chk.sv
// Concurrent checks on the observation register bank.
// Assumes it is bound to observation_bank and sees only that module's ports.
`timescale 1ns/10ps
module observation_bank_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [15:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   input wire logic transform_valid,
   input wire logic [15:0] d_axis_current_in,
   input wire logic [15:0] q_axis_current_in,
   input wire logic carrier_tick,
   input wire logic [15:0] carrier_angle_step
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   logic answer;
   logic in_window;
   logic angle_commit;
   assign answer = !waitrequest;
   assign in_window = address >= obs_pkg::IDX_ALPHA_TEST && address <= obs_pkg::IDX_LAST;
   assign angle_commit = answer && write && byteenable[0]
      && address == obs_pkg::IDX_ANGLE_STEP + 16'h0001;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_wait_one_low: assert property (answer |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_taken_answer: assert property (waitrequest && (read || write) |=> answer)
      else $error("request not answered in the next cycle");
   a_unmapped_err: assert property (answer && !in_window |->
      response == obs_pkg::RESP_SLVERR && readdata == obs_pkg::READ_RESET)
      else $error("unmapped access not refused");
   a_mapped_okay: assert property (answer && in_window |-> response == obs_pkg::RESP_OKAY)
      else $error("mapped access not okay");
   a_read_pad: assert property (answer && read |-> readdata[31:8] == obs_pkg::READ_PAD)
      else $error("read data upper bits not zero");
   a_d_now_read: assert property (transform_valid ##1 !transform_valid ##1 (!transform_valid
      && read && waitrequest && address == obs_pkg::IDX_D_NOW)
      |=> answer && readdata[7:0] == $past(d_axis_current_in[15:8], 3))
      else $error("d-axis word not loaded");
   a_q_now_read: assert property (transform_valid ##1 !transform_valid ##1 (!transform_valid
      && read && waitrequest && address == obs_pkg::IDX_Q_NOW)
      |=> answer && readdata[7:0] == $past(q_axis_current_in[15:8], 3))
      else $error("q-axis word not loaded");
   a_angle_write: assert property (angle_commit |=>
      carrier_angle_step[7:0] == $past(writedata[7:0]))
      else $error("angle low byte not committed");
   a_angle_hold: assert property ($changed(carrier_angle_step) |-> $past(angle_commit))
      else $error("angle step changed without a write");
   c_read: cover property (answer && read);
   c_unmapped: cover property (answer && !in_window);
   c_angle: cover property (angle_commit);
endmodule : observation_bank_chk

bind observation_bank observation_bank_chk u_chk (.clk(clk), .arst_n(arst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
   .response(response), .transform_valid(transform_valid),
   .d_axis_current_in(d_axis_current_in), .q_axis_current_in(q_axis_current_in),
   .carrier_tick(carrier_tick), .carrier_angle_step(carrier_angle_step));

// ### testbench/tb_top.sv
// Self-checking bench for the observation register bank.
// Assumes obs_pkg and the design files are compiled first.
`timescale 1ns/10ps
module tb_top;
   logic clk, arst_n, read, write, transform_valid, carrier_tick, injection_valid;
   logic [15:0] address, d_in, q_in, alpha_in, beta_in, ia_in, ib_in, ic_in, angle;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [1:0] response;
   logic waitrequest;
   int n_mismatch = 0;
   int n_compared = 0;
   observation_bank DUT (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response), .transform_valid(transform_valid),
      .d_axis_current_in(d_in), .q_axis_current_in(q_in), .carrier_tick(carrier_tick),
      .injection_valid(injection_valid), .injection_alpha_in(alpha_in),
      .injection_beta_in(beta_in), .injection_current_a_in(ia_in),
      .injection_current_b_in(ib_in), .injection_current_c_in(ic_in),
      .carrier_angle_step(angle));
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
         input logic [3:0] be, output logic [7:0] rd, output logic [1:0] rsp);
      int n;
      n = 0;
      @(posedge clk);
      address <= idx;
      writedata <= {24'h00_0000, wd};
      byteenable <= be;
      if (wr) write <= 1'b1;
      else read <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) check(32'h0000_0bad, 32'h0000_0000);
      rd = readdata[7:0];
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wr16(input logic [15:0] idx, input logic [15:0] v, input logic [3:0] be);
      logic [7:0] rd;
      logic [1:0] rsp;
      bus(1'b1, idx, v[15:8], be, rd, rsp);
      bus(1'b1, idx + 16'h0001, v[7:0], be, rd, rsp);
   endtask : wr16
   task automatic expect_word(input logic [15:0] idx, input logic [15:0] exp);
      logic [7:0] hi, lo;
      logic [1:0] r1, r2;
      bus(1'b0, idx, 8'h00, 4'h1, hi, r1);
      bus(1'b0, idx + 16'h0001, 8'h00, 4'h1, lo, r2);
      check({16'h0000, hi, lo}, {16'h0000, exp});
      check({28'h000_0000, r1, r2}, {28'h000_0000, obs_pkg::RESP_OKAY, obs_pkg::RESP_OKAY});
   endtask : expect_word
   task automatic strobe(input logic tv, input logic ct, input logic iv);
      @(posedge clk);
      transform_valid <= tv;
      carrier_tick <= ct;
      injection_valid <= iv;
      @(posedge clk);
      transform_valid <= 1'b0;
      carrier_tick <= 1'b0;
      injection_valid <= 1'b0;
   endtask : strobe
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset;
      for (int i = 0; i < 10; i++) expect_word(16'h40e6 + 16'(2 * i), 16'h0000);
      check({16'h0000, angle}, 32'h0000_0000);
      $display("reset values done");
   endtask : test_reset
   task automatic test_currents;
      d_in <= 16'h8000;
      q_in <= 16'h7fff;
      strobe(1'b1, 1'b0, 1'b0);
      expect_word(obs_pkg::IDX_D_NOW, 16'h8000);
      expect_word(obs_pkg::IDX_Q_NOW, 16'h7fff);
      expect_word(obs_pkg::IDX_D_PREV, 16'h0000);
      strobe(1'b0, 1'b1, 1'b0);
      d_in <= 16'hffff;
      q_in <= 16'h0001;
      strobe(1'b1, 1'b0, 1'b0);
      expect_word(obs_pkg::IDX_D_PREV, 16'h8000);
      expect_word(obs_pkg::IDX_Q_PREV, 16'h7fff);
      d_in <= 16'h1234;
      q_in <= 16'hfedc;
      strobe(1'b1, 1'b1, 1'b0);
      expect_word(obs_pkg::IDX_Q_NOW, 16'hfedc);
      expect_word(obs_pkg::IDX_D_NOW, 16'h1234);
      expect_word(obs_pkg::IDX_D_PREV, 16'hffff);
      expect_word(obs_pkg::IDX_Q_PREV, 16'h0001);
      $display("current words done");
   endtask : test_currents
   task automatic test_angle;
      logic [7:0] rd;
      logic [1:0] rsp;
      wr16(obs_pkg::IDX_ANGLE_STEP, 16'h8000, 4'h1);
      expect_word(obs_pkg::IDX_ANGLE_STEP, 16'h8000);
      check({16'h0000, angle}, 32'h0000_8000);
      wr16(obs_pkg::IDX_ANGLE_STEP, 16'h7fff, 4'h1);
      bus(1'b1, obs_pkg::IDX_ANGLE_STEP + 16'h0001, 8'h55, 4'h1, rd, rsp);
      wr16(obs_pkg::IDX_ANGLE_STEP, 16'h1234, 4'h0);
      expect_word(obs_pkg::IDX_ANGLE_STEP, 16'h7f55);
      check({16'h0000, angle}, 32'h0000_7f55);
      $display("angle step done");
   endtask : test_angle
   task automatic test_readonly;
      logic [15:0] idx [6];
      logic [15:0] val [6];
      idx = '{16'h40e6, 16'h40e8, 16'h40f4, 16'h40f6, 16'h40f8, 16'h40ea};
      val = '{16'h8001, 16'h7ffe, 16'h0102, 16'hfe03, 16'h4c05, 16'h1234};
      alpha_in <= val[0];
      beta_in <= val[1];
      ia_in <= val[2];
      ib_in <= val[3];
      ic_in <= val[4];
      strobe(1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 6; i++) begin
         wr16(idx[i], 16'h5a5a, 4'h1);
         expect_word(idx[i], val[i]);
      end
      $display("read-only words done");
   endtask : test_readonly
   task automatic test_unmapped;
      logic [7:0] rd;
      logic [1:0] rsp;
      logic [15:0] bad [3];
      bad = '{16'h40e5, 16'h40fa, 16'h0000};
      for (int i = 0; i < 3; i++) begin
         bus(1'(i % 2), bad[i], 8'hff, 4'h1, rd, rsp);
         check({22'h00_0000, rsp, rd}, {22'h00_0000, obs_pkg::RESP_SLVERR, 8'h00});
      end
      check({16'h0000, angle}, 32'h0000_7f55);
      $display("unmapped done");
   endtask : test_unmapped
   // ---------------------------------------------
   // Clock, reset, sequence and watchdog
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      arst_n = 1'b0;
      {read, write, transform_valid, carrier_tick, injection_valid} = 5'h00;
      {address, d_in, q_in, alpha_in, beta_in, ia_in, ib_in, ic_in} = 128'h0;
      writedata = 32'h0000_0000;
      byteenable = 4'h0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      test_reset();
      test_currents();
      test_angle();
      test_readonly();
      test_unmapped();
      print_verdict();
   end
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
endmodule : tb_top
